/* File: design/egress_port_sched.sv */
// four-queue transmit scheduler of one network port
// assumes the MAC holds off accept until it starts the granted packet
`timescale 1ns/100ps
`default_nettype none
module egress_port_sched (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] cfgUpper,
  input wire logic [15:0] cfgLower,
  input wire logic [3:0] queuePending,
  input wire logic grantAccept,
  input wire logic periodTick,
  output logic grantValid,
  output logic [1:0] grantQueue,
  output logic [3:0] queueExhausted
);

  localparam int CW = egress_sched_pkg::CNT_W;

  typedef struct packed {
    logic [3:0][CW-1:0] sent;
    logic valid;
    logic [1:0] queue;
  } port_state_t;

  port_state_t state_reg;
  port_state_t state_next;

  // ----------------------------------------------------------------
  // field access per queue
  // ----------------------------------------------------------------
  function automatic logic modeOf(input int q, input logic [15:0] up,
                                  input logic [15:0] lo);
    case (q)
      3: modeOf = up[egress_sched_pkg::LO_MODE_BIT];
      2: modeOf = up[egress_sched_pkg::HI_MODE_BIT];
      1: modeOf = lo[egress_sched_pkg::LO_MODE_BIT];
      default: modeOf = lo[egress_sched_pkg::HI_MODE_BIT];
    endcase
  endfunction : modeOf

  function automatic logic [CW-1:0] limitOf(input int q,
                                            input logic [15:0] up,
                                            input logic [15:0] lo);
    case (q)
      3: limitOf = up[egress_sched_pkg::LO_CNT_LSB +: CW];
      2: limitOf = up[egress_sched_pkg::HI_CNT_LSB +: CW];
      1: limitOf = lo[egress_sched_pkg::LO_CNT_LSB +: CW];
      default: limitOf = lo[egress_sched_pkg::HI_CNT_LSB +: CW];
    endcase
  endfunction : limitOf

  // ----------------------------------------------------------------
  // counting and selection
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] eligible;
    logic found;
    eligible = 4'h0;
    found = 1'b0;
    state_next = state_reg;
    if (periodTick) begin
      state_next.sent = '0;
    end
    if (state_reg.valid && grantAccept) begin
      state_next.valid = 1'b0;
      // a packet taken in the reload cycle still counts in the new period
      if (state_next.sent[state_reg.queue] != {CW{1'b1}}) begin
        state_next.sent[state_reg.queue] =
          state_next.sent[state_reg.queue] + CW'(1);
      end
    end
    for (int q = 0; q < 4; q++) begin
      // strict queues are never limited, ratio queues stop at their count
      eligible[q] = queuePending[q] &&
        (!modeOf(q, cfgUpper, cfgLower) ||
         state_next.sent[q] < limitOf(q, cfgUpper, cfgLower));
    end
    // highest queue wins; strict drains fully before lower ones
    if (!state_reg.valid) begin
      for (int q = 3; q >= 0; q--) begin
        if (eligible[q] && !found) begin
          found = 1'b1;
          state_next.valid = 1'b1;
          state_next.queue = 2'(q);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign grantValid = state_reg.valid;
  assign grantQueue = state_reg.queue;

  generate
    for (genvar g = 0; g < 4; g++) begin : gen_exh
      assign queueExhausted[g] = modeOf(g, cfgUpper, cfgLower) &&
        state_reg.sent[g] >= limitOf(g, cfgUpper, cfgLower);
    end
  endgenerate

endmodule : egress_port_sched
`default_nettype wire

/* File: design/egress_queue_ratio_scheduler.sv */
// egress queue scheduler for the two network ports, with its registers
// assumes one AHB-Lite master, one core clock, MACs that accept grants
//
// Behaviour
// - with queue 3 strict, every waiting queue 3 packet goes before lower.
// - with queue 3 in ratio mode, it sends at most its count per period.
// - queue 3 count is bits 6..0, read/write, reset 0x08, mode reset 1.
// - with queue 2 strict, every waiting queue 2 packet goes before lower.
// - with queue 2 in ratio mode, bits 14..8 limit it per period.
// - queue 2 count is read/write, reset 0x04, mode bit reset 1.
// - queue 0 mode is bit 15 of the lower register, strict or limited.
// - queue 0 count is bits 14..8 of the lower register, reset 0x01.
// - queue 1 mode is bit 7 of the lower register, strict or limited.
// - queue 1 count is bits 6..0 of the lower register, reset 0x02.
// - each port owns its own upper and lower scheduler registers.
`timescale 1ns/100ps
`default_nettype none
module egress_queue_ratio_scheduler #(
  parameter int PERIOD_CYCLES = egress_sched_pkg::SCHED_PERIOD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] port1Pending,
  input wire logic port1GrantAccept,
  output logic port1GrantValid,
  output logic [1:0] port1GrantQueue,
  input wire logic [3:0] port2Pending,
  input wire logic port2GrantAccept,
  output logic port2GrantValid,
  output logic [1:0] port2GrantQueue
);

  typedef struct packed {
    logic [1:0][15:0] upper;
    logic [1:0][15:0] lower;
    logic wrPend;
    logic [2:0] wrSel;
    logic [31:0] rdata;
    logic readyOut;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  logic periodTick;
  logic [1:0][3:0] pending;
  logic [1:0] accept;
  logic [1:0] grantValid;
  logic [1:0][1:0] grantQueue;
  logic [1:0][3:0] exhausted;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] regSel(input logic [31:0] addr);
    if (addr == egress_sched_pkg::PORT1_UPPER_ADDR) begin
      regSel = egress_sched_pkg::SEL_P1_UPPER;
    end else if (addr == egress_sched_pkg::PORT1_LOWER_ADDR) begin
      regSel = egress_sched_pkg::SEL_P1_LOWER;
    end else if (addr == egress_sched_pkg::PORT2_UPPER_ADDR) begin
      regSel = egress_sched_pkg::SEL_P2_UPPER;
    end else if (addr == egress_sched_pkg::PORT2_LOWER_ADDR) begin
      regSel = egress_sched_pkg::SEL_P2_LOWER;
    end else if (addr == egress_sched_pkg::SCHED_STATUS_ADDR) begin
      regSel = egress_sched_pkg::SEL_STATUS;
    end else begin
      regSel = egress_sched_pkg::SEL_NONE;
    end
  endfunction : regSel

  // ----------------------------------------------------------------
  // bus slave and register file
  // ----------------------------------------------------------------
  always_comb begin
    logic addrPhase;
    logic [2:0] sel;
    addrPhase = hsel && htrans[1] && hready;
    sel = regSel(haddr);
    state_next = state_reg;
    state_next.readyOut = 1'b1;
    // zero wait state: write lands in the data phase cycle
    if (state_reg.wrPend) begin
      case (state_reg.wrSel)
        egress_sched_pkg::SEL_P1_UPPER: begin
          state_next.upper[0] = hwdata[15:0];
        end
        egress_sched_pkg::SEL_P1_LOWER: begin
          state_next.lower[0] = hwdata[15:0];
        end
        egress_sched_pkg::SEL_P2_UPPER: begin
          state_next.upper[1] = hwdata[15:0];
        end
        egress_sched_pkg::SEL_P2_LOWER: begin
          state_next.lower[1] = hwdata[15:0];
        end
        default: begin
          state_next.upper = state_reg.upper;
        end
      endcase
    end
    state_next.wrPend = addrPhase && hwrite;
    state_next.wrSel = sel;
    // read data is latched at the address phase, so a read right after
    // a write to the same register would see the old value
    state_next.rdata = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      case (sel)
        egress_sched_pkg::SEL_P1_UPPER: begin
          state_next.rdata = {16'h0000, state_reg.upper[0]};
        end
        egress_sched_pkg::SEL_P1_LOWER: begin
          state_next.rdata = {16'h0000, state_reg.lower[0]};
        end
        egress_sched_pkg::SEL_P2_UPPER: begin
          state_next.rdata = {16'h0000, state_reg.upper[1]};
        end
        egress_sched_pkg::SEL_P2_LOWER: begin
          state_next.rdata = {16'h0000, state_reg.lower[1]};
        end
        egress_sched_pkg::SEL_STATUS: begin
          state_next.rdata = {22'h0, grantValid, exhausted[1],
                              exhausted[0]};
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg.upper <= {2{egress_sched_pkg::UPPER_RESET}};
      state_reg.lower <= {2{egress_sched_pkg::LOWER_RESET}};
      state_reg.wrPend <= 1'b0;
      state_reg.wrSel <= 3'h7;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.readyOut <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = state_reg.readyOut;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;

  // ----------------------------------------------------------------
  // period and per-port schedulers
  // ----------------------------------------------------------------
  sched_period_ticker #(
    .PERIOD_CYCLES(PERIOD_CYCLES)
  ) u_ticker (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .periodTick(periodTick)
  );

  assign pending[0] = port1Pending;
  assign pending[1] = port2Pending;
  assign accept[0] = port1GrantAccept;
  assign accept[1] = port2GrantAccept;

  generate
    for (genvar p = 0; p < 2; p++) begin : gen_port
      egress_port_sched u_sched (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .cfgUpper(state_reg.upper[p]),
        .cfgLower(state_reg.lower[p]),
        .queuePending(pending[p]),
        .grantAccept(accept[p]),
        .periodTick(periodTick),
        .grantValid(grantValid[p]),
        .grantQueue(grantQueue[p]),
        .queueExhausted(exhausted[p])
      );
    end
  endgenerate

  assign port1GrantValid = grantValid[0];
  assign port1GrantQueue = grantQueue[0];
  assign port2GrantValid = grantValid[1];
  assign port2GrantQueue = grantQueue[1];

endmodule : egress_queue_ratio_scheduler
`default_nettype wire

/* File: design/egress_sched_pkg.sv */
// constants shared by the egress queue scheduler files
// assumes a 20 MHz switch core clock and a 32-bit AHB-Lite register bus
package egress_sched_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT1_UPPER_IDX = 8'hC8;
  localparam logic [7:0] PORT1_LOWER_IDX = 8'hCA;
  localparam logic [7:0] PORT2_UPPER_IDX = 8'hCC;
  localparam logic [7:0] PORT2_LOWER_IDX = 8'hCE;
  localparam logic [7:0] SCHED_STATUS_IDX = 8'hC4;
  localparam logic [31:0] PORT1_UPPER_ADDR = {22'h0, PORT1_UPPER_IDX, 2'h0};
  localparam logic [31:0] PORT1_LOWER_ADDR = {22'h0, PORT1_LOWER_IDX, 2'h0};
  localparam logic [31:0] PORT2_UPPER_ADDR = {22'h0, PORT2_UPPER_IDX, 2'h0};
  localparam logic [31:0] PORT2_LOWER_ADDR = {22'h0, PORT2_LOWER_IDX, 2'h0};
  localparam logic [31:0] SCHED_STATUS_ADDR = {22'h0, SCHED_STATUS_IDX, 2'h0};

  // ----------------------------------------------------------------
  // field layout of a scheduler register
  // ----------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam int HI_MODE_BIT = 15;
  localparam int HI_CNT_LSB = 8;
  localparam int LO_MODE_BIT = 7;
  localparam int LO_CNT_LSB = 0;
  localparam logic [15:0] UPPER_RESET = 16'h8488;
  localparam logic [15:0] LOWER_RESET = 16'h8182;

  // ----------------------------------------------------------------
  // register select codes and timing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_P1_UPPER = 3'b000,
    SEL_P1_LOWER = 3'b001,
    SEL_P2_UPPER = 3'b010,
    SEL_P2_LOWER = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_NONE = 3'b111
  } reg_sel_t;

  localparam int CLK_HZ = 20_000_000;
  localparam int SCHED_PERIOD_US = 100;
  localparam int SCHED_PERIOD_CYCLES = (CLK_HZ / 1_000_000) * SCHED_PERIOD_US;

endpackage : egress_sched_pkg

/* File: design/sched_period_ticker.sv */
// fixed scheduling period divider
// assumes one free running core clock
`timescale 1ns/100ps
`default_nettype none
module sched_period_ticker #(
  parameter int PERIOD_CYCLES = egress_sched_pkg::SCHED_PERIOD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic periodTick
);

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } ticker_state_t;

  ticker_state_t state_reg;
  ticker_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count == 16'(PERIOD_CYCLES - 1)) begin
      state_next.count = 16'h0000;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign periodTick = state_reg.tick;

endmodule : sched_period_ticker
`default_nettype wire

/* File: sim/egress_mac_model.sv */
// transmit path model of one port: pending queues, grant acceptance
// assumes grants stand until accepted, as the scheduler promises
`timescale 1ns/100ps
`default_nettype none
module egress_mac_model #(
  parameter int ACCEPT_DELAY = 0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] pendSet,
  input wire logic clrCnt,
  input wire logic grantValid,
  input wire logic [1:0] grantQueue,
  output logic [3:0] pending,
  output logic grantAccept,
  output logic [3:0][7:0] sentCnt
);
  int waitCnt;
  assign pending = pendSet;
  // ----------------------------------------------------------------
  // accept each grant after a delay; slow ports stress the hold
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      grantAccept <= 1'b0;
      waitCnt <= 0;
      sentCnt <= '0;
    end else begin
      grantAccept <= 1'b0;
      if (clrCnt) sentCnt <= '0;
      if (grantValid && !grantAccept) begin
        if (waitCnt >= ACCEPT_DELAY) begin
          grantAccept <= 1'b1;
          sentCnt[grantQueue] <= sentCnt[grantQueue] + 8'h01;
          waitCnt <= 0;
        end else waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule : egress_mac_model
`default_nettype wire

/* File: sim/egress_queue_ratio_scheduler_props.sv */
// assertions on the bus and grant ports of the scheduler top
// assumes it is bound to the top module of the scheduler
`timescale 1ns/100ps
`default_nettype none
module egress_sched_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] port1Pending,
  input wire logic port1GrantAccept,
  input wire logic port1GrantValid,
  input wire logic [1:0] port1GrantQueue,
  input wire logic [3:0] port2Pending,
  input wire logic port2GrantAccept,
  input wire logic port2GrantValid,
  input wire logic [1:0] port2GrantQueue
);
  logic rdTaken;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  assign rdTaken = hsel && htrans[1] && hready && !hwrite;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rd_idle_zero_a: assert property (
    !rdTaken |=> hrdata == 32'h0000_0000)
    else $error("read data left standing");
  rd_upper_zero_a: assert property (
    rdTaken |=> hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  p1_hold_a: assert property (
    port1GrantValid && !port1GrantAccept
      |=> port1GrantValid && $stable(port1GrantQueue))
    else $error("port 1 grant not held");
  p1_drop_a: assert property (
    port1GrantValid && port1GrantAccept |=> !port1GrantValid)
    else $error("port 1 grant not dropped");
  p1_pend_a: assert property (
    $rose(port1GrantValid)
      |-> |($past(port1Pending) & (4'h1 << port1GrantQueue)))
    else $error("port 1 grant for empty queue");
  p2_hold_a: assert property (
    port2GrantValid && !port2GrantAccept
      |=> port2GrantValid && $stable(port2GrantQueue))
    else $error("port 2 grant not held");
  p2_drop_a: assert property (
    port2GrantValid && port2GrantAccept |=> !port2GrantValid)
    else $error("port 2 grant not dropped");
  p2_pend_a: assert property (
    $rose(port2GrantValid)
      |-> |($past(port2Pending) & (4'h1 << port2GrantQueue)))
    else $error("port 2 grant for empty queue");
endmodule : egress_sched_checker
bind egress_queue_ratio_scheduler egress_sched_checker i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .port1Pending(port1Pending),
  .port1GrantAccept(port1GrantAccept), .port1GrantValid(port1GrantValid),
  .port1GrantQueue(port1GrantQueue), .port2Pending(port2Pending),
  .port2GrantAccept(port2GrantAccept),
  .port2GrantValid(port2GrantValid), .port2GrantQueue(port2GrantQueue));
`default_nettype wire

/* File: sim/egress_queue_ratio_scheduler_test.sv */
// self-checking bench for the two-port egress queue scheduler
// assumes design files, MAC model and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module egress_queue_ratio_scheduler_test;
  localparam int PER = 200;
  localparam logic [31:0] STAT = egress_sched_pkg::SCHED_STATUS_ADDR;
  localparam logic [3:0][31:0] ADDR = {egress_sched_pkg::PORT2_LOWER_ADDR,
    egress_sched_pkg::PORT2_UPPER_ADDR, egress_sched_pkg::PORT1_LOWER_ADDR,
    egress_sched_pkg::PORT1_UPPER_ADDR};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [1:0][3:0] pendSet = '0;
  logic [1:0] clrCnt = '0;
  wire [1:0][3:0] pending;
  wire [1:0] accept, gValid;
  wire [1:0][1:0] gQueue;
  wire [1:0][3:0][7:0] sent;
  int errorCnt = 0;
  int checks = 0;
  int cyc = 0;
  egress_queue_ratio_scheduler #(.PERIOD_CYCLES(PER)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port1Pending(pending[0]),
    .port1GrantAccept(accept[0]), .port1GrantValid(gValid[0]),
    .port1GrantQueue(gQueue[0]), .port2Pending(pending[1]),
    .port2GrantAccept(accept[1]), .port2GrantValid(gValid[1]),
    .port2GrantQueue(gQueue[1]));
  egress_mac_model #(.ACCEPT_DELAY(0)) i_mac1 (.clk_sys(clk_sys),
    .rstn(rstn), .pendSet(pendSet[0]), .clrCnt(clrCnt[0]),
    .grantValid(gValid[0]), .grantQueue(gQueue[0]), .pending(pending[0]),
    .grantAccept(accept[0]), .sentCnt(sent[0]));
  egress_mac_model #(.ACCEPT_DELAY(3)) i_mac2 (.clk_sys(clk_sys),
    .rstn(rstn), .pendSet(pendSet[1]), .clrCnt(clrCnt[1]),
    .grantValid(gValid[1]), .grantQueue(gQueue[1]), .pending(pending[1]),
    .grantAccept(accept[1]), .sentCnt(sent[1]));
  // ----------------------------------------------------------------
  // clock, cycle count from release, hang limit
  // ----------------------------------------------------------------
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= rstn ? cyc + 1 : 0;
    if (cyc > 20000) begin
      errorCnt++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // tasks; bus tasks are entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rdchk(input logic [31:0] a, exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk($sformatf("reg %h", a), exp, rd);
  endtask : rdchk
  // one period-aligned window; exp nibble q is the count, F unlimited
  task automatic run(input int p, input logic [15:0] up, lo,
                     input logic [3:0] pd, input logic [15:0] exp,
                     input logic [31:0] st);
    wr(ADDR[2*p], {16'h0000, up});
    wr(ADDR[2*p+1], {16'h0000, lo});
    while (cyc % PER != 5) @(posedge clk_sys);
    clrCnt[p] <= 1'b1;
    pendSet[p] <= pd;
    @(posedge clk_sys);
    clrCnt[p] <= 1'b0;
    while (cyc % PER != PER - 40) @(posedge clk_sys);
    pendSet[p] <= 4'h0;
    repeat (10) @(posedge clk_sys);
    for (int q = 0; q < 4; q++) begin
      if (exp[4*q +: 4] == 4'hF)
        chk("unlimited", 32'h1, {31'h0, sent[p][q] > 8'h08});
      else
        chk("sent", {28'h0, exp[4*q +: 4]}, {24'h0, sent[p][q]});
    end
    rdchk(STAT, st);
  endtask : run
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
      rdchk(ADDR[i], i[0] ? 32'h8182 : 32'h8488);
    wr(32'h4, 32'hFFFF_FFFF);
    wr(STAT, 32'hFFFF_FFFF);
    rdchk(32'h4, 32'h0);
    rdchk(STAT, 32'h0);
    for (int i = 0; i < 4; i++) wr(ADDR[i], 32'hFFFF_1200 + 32'h0101 * i);
    for (int i = 0; i < 4; i++)
      rdchk(ADDR[i], 32'h1200 + 32'h0101 * i);
    run(0, 16'h8488, 16'h8182, 4'hF, 16'h8421, 32'hF);
    run(0, 16'h8408, 16'h8182, 4'hF, 16'hF000, 32'h0);
    run(0, 16'h0482, 16'h8182, 4'hF, 16'h2F00, 32'h8);
    run(1, 16'h8488, 16'h0102, 4'h3, 16'h00F0, 32'h0);
    run(1, 16'h8488, 16'h0102, 4'h1, 16'h000F, 32'h0);
    run(1, 16'h8281, 16'h8383, 4'hF, 16'h1233, 32'hF0);
    run(0, 16'h8080, 16'h8182, 4'hE, 16'h0020, 32'hE);
    tally_and_finish();
  end
endmodule : egress_queue_ratio_scheduler_test
`default_nettype wire
